/* ssdr_defines.svh */
/*
 Constants for the source-synchronous DDR output and realignment block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SSDR_DEFINES_SVH
`define SSDR_DEFINES_SVH

// ==========================================================
// Inversion select field positions
`define SSDR_INV_RX_BIT   0
`define SSDR_INV_HI_BIT   1
`define SSDR_INV_LO_BIT   2
`define SSDR_INV_W        3

// ==========================================================
// Forwarded clock division codes
`define SSDR_DIV_W        4
`define SSDR_DIV_BYPASS   4'h1
`define SSDR_DIV_HALF     4'h2

// ==========================================================
// Reset values
`define SSDR_RST_SYNC     2'h3
`define SSDR_BIT_IDLE     1'b0

`endif

/* ssdr_pkg.sv */
/*
 Types shared by the source-synchronous DDR block.
 Assumes nothing of its surroundings.
*/
package ssdr_pkg;

    typedef enum logic [1:0] {
        SSDR_TX_IDLE = 2'h1,
        SSDR_TX_SEND = 2'h2
    } ssdr_tx_state_t;

endpackage

/* ssdr_top.sv */
/*
 Source-synchronous I/O datapath: gray-pointer FIFOs, DDR transmit stage,
 forwarded clock generator and receive deserializer with bit slip.
 Assumes link_clk is a free-running high-speed clock and that the
 configuration inputs change only while the link is idle.
*/
// Summary of operation
// - Two output registers each take one fabric data path on the link clock rising edge.
// - The clock level itself selects between the two registers, giving two bits per clock.
// - The pin carries the first register while the clock is high, the second while low.
// - The forwarded clock leaves on a data channel built like the data pin.
// - At full bit rate the link clock goes straight to the clock pin, bypassing the serializer.
// - For divided rates the serializer itself produces the forwarded clock pattern.
// - Each realignment request stalls the deserializer word count by exactly one bit.
// - The receive input and both data-pin registers have their own selectable inversion; the forwarded clock channel has none.
`timescale 1ns/100ps
`include "ssdr_defines.svh"

// ==========================================================
// Dual-clock FIFO with gray-coded pointers
module ssdr_afifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             wr_clk,
    input  wire logic             wr_rst,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_clk,
    input  wire logic             rd_rst,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("ssdr_afifo: DEPTH must be a power of two of at least 4");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wbin_q;
    logic [AW:0]      wgray_q;
    logic [AW:0]      rbin_q;
    logic [AW:0]      rgray_q;
    logic [AW:0]      rg_s1_q;
    logic [AW:0]      rg_s2_q;
    logic [AW:0]      wg_s1_q;
    logic [AW:0]      wg_s2_q;
    logic [AW:0]      wbin_d;
    logic [AW:0]      rbin_d;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    assign wr_ready = (wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
    assign rd_valid = (rgray_q != wg_s2_q);
    assign rd_data  = mem_q[rbin_q[AW-1:0]];
    assign wbin_d   = wbin_q + 1'b1;
    assign rbin_d   = rbin_q + 1'b1;

    always_ff @(posedge wr_clk) begin
        if (wr_valid && wr_ready) begin
            mem_q[wbin_q[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge wr_clk or posedge wr_rst) begin
        if (wr_rst) begin
            wbin_q  <= '0;
            wgray_q <= '0;
            rg_s1_q <= '0;
            rg_s2_q <= '0;
        end else begin
            rg_s1_q <= rgray_q;
            rg_s2_q <= rg_s1_q;
            if (wr_valid && wr_ready) begin
                wbin_q  <= wbin_d;
                wgray_q <= to_gray(wbin_d);
            end
        end
    end

    always_ff @(posedge rd_clk or posedge rd_rst) begin
        if (rd_rst) begin
            rbin_q  <= '0;
            rgray_q <= '0;
            wg_s1_q <= '0;
            wg_s2_q <= '0;
        end else begin
            wg_s1_q <= wgray_q;
            wg_s2_q <= wg_s1_q;
            if (rd_valid && rd_ready) begin
                rbin_q  <= rbin_d;
                rgray_q <= to_gray(rbin_d);
            end
        end
    end
endmodule

// ==========================================================
// Top level
module ssdr_top #(
    parameter int WORD_W = 8,
    parameter int DEPTH  = 16
) (
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    link_clk,
    input  wire logic [WORD_W-1:0]       tx_word,
    input  wire logic                    tx_valid,
    output logic                         tx_ready,
    input  wire logic [`SSDR_DIV_W-1:0]  fwd_div,
    input  wire logic [`SSDR_INV_W-1:0]  inv_sel,
    input  wire logic                    rx_slip,
    output logic      [WORD_W-1:0]       rx_word,
    output logic                         rx_valid,
    input  wire logic                    rx_ready,
    output logic                         rx_overflow,
    output logic                         tx_data_pin,
    output logic                         tx_clk_pin,
    input  wire logic                    rx_data_pin
);
    localparam int PW   = $clog2(WORD_W);
    localparam int CFGW = `SSDR_DIV_W + `SSDR_INV_W;
    localparam logic [PW-1:0] PAIR_LAST = PW'(WORD_W / 2 - 1);
    localparam logic [PW-1:0] BIT_LAST  = PW'(WORD_W - 1);

    if (WORD_W < 4 || (WORD_W % 2) != 0) begin : g_chk
        $error("ssdr_top: WORD_W must be even and at least 4");
    end

    // ======================================================
    // Link-domain reset and crossings
    logic                      lrst_s1_q;
    logic                      link_rst_q;
    logic [CFGW-1:0]           cfg_s1_q;
    logic [CFGW-1:0]           cfg_s2_q;
    logic                      rx_p1_q;
    logic                      rx_p2_q;
    logic                      slip_tgl_q;
    logic                      sl_s1_q;
    logic                      sl_s2_q;
    logic                      sl_s3_q;
    logic                      ovf_q;
    logic                      ovf_s1_q;
    logic                      ovf_s2_q;
    logic [`SSDR_DIV_W-1:0]    div_s;
    logic [`SSDR_INV_W-1:0]    inv_s;
    logic                      slip_evt;
    logic                      clk_byp;

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {lrst_s1_q, link_rst_q} <= `SSDR_RST_SYNC;
        end else begin
            {lrst_s1_q, link_rst_q} <= {1'b0, lrst_s1_q};
        end
    end

    always_ff @(posedge link_clk or posedge link_rst_q) begin
        if (link_rst_q) begin
            cfg_s1_q <= '0;
            cfg_s2_q <= '0;
            rx_p1_q  <= `SSDR_BIT_IDLE;
            rx_p2_q  <= `SSDR_BIT_IDLE;
            sl_s1_q  <= 1'b0;
            sl_s2_q  <= 1'b0;
            sl_s3_q  <= 1'b0;
        end else begin
            cfg_s1_q <= {fwd_div, inv_sel};
            cfg_s2_q <= cfg_s1_q;
            rx_p1_q  <= rx_data_pin;
            rx_p2_q  <= rx_p1_q;
            sl_s1_q  <= slip_tgl_q;
            sl_s2_q  <= sl_s1_q;
            sl_s3_q  <= sl_s2_q;
        end
    end

    assign div_s    = cfg_s2_q[CFGW-1:`SSDR_INV_W];
    assign inv_s    = cfg_s2_q[`SSDR_INV_W-1:0];
    assign slip_evt = sl_s2_q ^ sl_s3_q;
    assign clk_byp  = (div_s <= `SSDR_DIV_BYPASS);

    // Each slip request flips a toggle for the link domain
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            slip_tgl_q <= 1'b0;
            ovf_s1_q   <= 1'b0;
            ovf_s2_q   <= 1'b0;
        end else begin
            slip_tgl_q <= slip_tgl_q ^ rx_slip;
            ovf_s1_q   <= ovf_q;
            ovf_s2_q   <= ovf_s1_q;
        end
    end

    assign rx_overflow = ovf_s2_q;

    // ======================================================
    // Transmit FIFO and DDR serializer
    logic [WORD_W-1:0]         txf_word;
    logic                      txf_valid;
    logic                      tx_load;
    ssdr_pkg::ssdr_tx_state_t  tx_st_q;
    logic [WORD_W-1:0]         tx_sh_q;
    logic [PW-1:0]             tx_pos_q;
    logic                      tx_hi_q;
    logic                      tx_lo_q;

    ssdr_afifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_tx_fifo (
        .wr_clk   (core_clk),
        .wr_rst   (sys_rst),
        .wr_valid (tx_valid),
        .wr_ready (tx_ready),
        .wr_data  (tx_word),
        .rd_clk   (link_clk),
        .rd_rst   (link_rst_q),
        .rd_valid (txf_valid),
        .rd_ready (tx_load),
        .rd_data  (txf_word)
    );

    assign tx_load = txf_valid &&
                     (tx_st_q == ssdr_pkg::SSDR_TX_IDLE || tx_pos_q == PAIR_LAST);

    always_ff @(posedge link_clk or posedge link_rst_q) begin
        if (link_rst_q) begin
            tx_st_q  <= ssdr_pkg::SSDR_TX_IDLE;
            tx_sh_q  <= '0;
            tx_pos_q <= '0;
            tx_hi_q  <= `SSDR_BIT_IDLE;
            tx_lo_q  <= `SSDR_BIT_IDLE;
        end else if (tx_load) begin
            tx_st_q  <= ssdr_pkg::SSDR_TX_SEND;
            tx_sh_q  <= {txf_word[WORD_W-3:0], 2'h0};
            tx_pos_q <= '0;
            tx_hi_q  <= txf_word[WORD_W-1] ^ inv_s[`SSDR_INV_HI_BIT];
            tx_lo_q  <= txf_word[WORD_W-2] ^ inv_s[`SSDR_INV_LO_BIT];
        end else begin
            unique case (tx_st_q)
                ssdr_pkg::SSDR_TX_SEND: begin
                    if (tx_pos_q == PAIR_LAST) begin
                        tx_st_q <= ssdr_pkg::SSDR_TX_IDLE;
                        tx_hi_q <= `SSDR_BIT_IDLE;
                        tx_lo_q <= `SSDR_BIT_IDLE;
                    end else begin
                        tx_sh_q  <= {tx_sh_q[WORD_W-3:0], 2'h0};
                        tx_pos_q <= tx_pos_q + 1'b1;
                        tx_hi_q  <= tx_sh_q[WORD_W-1] ^ inv_s[`SSDR_INV_HI_BIT];
                        tx_lo_q  <= tx_sh_q[WORD_W-2] ^ inv_s[`SSDR_INV_LO_BIT];
                    end
                end
                ssdr_pkg::SSDR_TX_IDLE: begin
                    tx_hi_q <= `SSDR_BIT_IDLE;
                    tx_lo_q <= `SSDR_BIT_IDLE;
                end
            endcase
        end
    end

    // Clock level picks the register
    assign tx_data_pin = link_clk ? tx_hi_q : tx_lo_q;

    // ======================================================
    // Forwarded clock pattern, counted in bit times
    logic [`SSDR_DIV_W-1:0]    fc_q;
    logic                      clk_hi_q;
    logic                      clk_lo_q;

    function automatic logic [`SSDR_DIV_W-1:0] bit_wrap(
        input logic [`SSDR_DIV_W-1:0] pos,
        input logic [`SSDR_DIV_W-1:0] step,
        input logic [`SSDR_DIV_W-1:0] div
    );
        logic [`SSDR_DIV_W:0] sum;
        sum = {1'b0, pos} + {1'b0, step};
        if (pos >= div) begin
            return '0;
        end else if (sum >= {1'b0, div}) begin
            return `SSDR_DIV_W'(sum - {1'b0, div});
        end
        return sum[`SSDR_DIV_W-1:0];
    endfunction

    always_ff @(posedge link_clk or posedge link_rst_q) begin
        if (link_rst_q) begin
            fc_q     <= '0;
            clk_hi_q <= `SSDR_BIT_IDLE;
            clk_lo_q <= `SSDR_BIT_IDLE;
        end else if (clk_byp) begin
            fc_q     <= '0;
            clk_hi_q <= `SSDR_BIT_IDLE;
            clk_lo_q <= `SSDR_BIT_IDLE;
        end else begin
            fc_q     <= bit_wrap(fc_q, `SSDR_DIV_HALF, div_s);
            clk_hi_q <= (fc_q < (div_s >> 1));
            clk_lo_q <= (bit_wrap(fc_q, `SSDR_DIV_BYPASS, div_s) < (div_s >> 1));
        end
    end

    // Same DDR mux as the data pin; full rate takes the PLL clock itself
    assign tx_clk_pin = clk_byp ? link_clk : (link_clk ? clk_hi_q : clk_lo_q);

    // ======================================================
    // Receive deserializer with bit slip
    logic [WORD_W-1:0]         rx_sh_q;
    logic [PW-1:0]             rx_cnt_q;
    logic [WORD_W-1:0]         rxw_q;
    logic                      rxw_valid_q;
    logic                      rxf_ready;
    logic                      rx_bit;

    assign rx_bit = rx_p2_q ^ inv_s[`SSDR_INV_RX_BIT];

    always_ff @(posedge link_clk or posedge link_rst_q) begin
        if (link_rst_q) begin
            rx_sh_q     <= '0;
            rx_cnt_q    <= '0;
            rxw_q       <= '0;
            rxw_valid_q <= 1'b0;
            ovf_q       <= 1'b0;
        end else begin
            rx_sh_q     <= {rx_sh_q[WORD_W-2:0], rx_bit};
            rxw_valid_q <= 1'b0;
            if (slip_evt) begin
                rx_cnt_q <= rx_cnt_q;
            end else if (rx_cnt_q == BIT_LAST) begin
                rx_cnt_q    <= '0;
                rxw_q       <= {rx_sh_q[WORD_W-2:0], rx_bit};
                rxw_valid_q <= 1'b1;
            end else begin
                rx_cnt_q <= rx_cnt_q + 1'b1;
            end
            if (rxw_valid_q && !rxf_ready) begin
                ovf_q <= 1'b1;
            end
        end
    end

    ssdr_afifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .wr_clk   (link_clk),
        .wr_rst   (link_rst_q),
        .wr_valid (rxw_valid_q),
        .wr_ready (rxf_ready),
        .wr_data  (rxw_q),
        .rd_clk   (core_clk),
        .rd_rst   (sys_rst),
        .rd_valid (rx_valid),
        .rd_ready (rx_ready),
        .rd_data  (rx_word)
    );

    // ======================================================
    // Assertions
    property p_rise_load;
        @(posedge link_clk) disable iff (link_rst_q)
        tx_load |=> tx_hi_q == ($past(txf_word[WORD_W-1]) ^ $past(inv_s[`SSDR_INV_HI_BIT]))
                 && tx_lo_q == ($past(txf_word[WORD_W-2]) ^ $past(inv_s[`SSDR_INV_LO_BIT]));
    endproperty
    a_rise_load: assert property (p_rise_load) else $error("DDR registers missed a load");

    property p_pin_high;
        @(negedge link_clk) disable iff (link_rst_q)
        tx_data_pin == tx_hi_q;
    endproperty
    a_pin_high: assert property (p_pin_high) else $error("Pin not first bit while high");

    property p_pin_low;
        @(posedge link_clk) disable iff (link_rst_q)
        tx_data_pin == tx_lo_q;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("Pin not second bit while low");

    property p_byp_high;
        @(negedge link_clk) disable iff (link_rst_q)
        clk_byp |-> tx_clk_pin;
    endproperty
    a_byp_high: assert property (p_byp_high) else $error("Bypass clock pin low while high");

    property p_byp_low;
        @(posedge link_clk) disable iff (link_rst_q)
        clk_byp |-> !tx_clk_pin;
    endproperty
    a_byp_low: assert property (p_byp_low) else $error("Bypass clock pin high while low");

    property p_half_rate;
        @(posedge link_clk) disable iff (link_rst_q)
        (div_s == `SSDR_DIV_HALF) [*3] |-> clk_hi_q != clk_lo_q;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("Half-rate clock pattern wrong");

    property p_slip_hold;
        @(posedge link_clk) disable iff (link_rst_q)
        slip_evt |=> rx_cnt_q == $past(rx_cnt_q) && !rxw_valid_q;
    endproperty
    a_slip_hold: assert property (p_slip_hold) else $error("Slip did not hold one bit");

    property p_word_step;
        @(posedge link_clk) disable iff (link_rst_q)
        !slip_evt && rx_cnt_q == BIT_LAST |=> rx_cnt_q == '0 && rxw_valid_q ##1 !rxw_valid_q;
    endproperty
    a_word_step: assert property (p_word_step) else $error("Word not emitted at boundary");

    property p_rx_invert;
        @(posedge link_clk) disable iff (link_rst_q)
        !link_rst_q ##1 rx_sh_q[0] == ($past(rx_p2_q) ^ $past(inv_s[`SSDR_INV_RX_BIT]));
    endproperty
    a_rx_invert: assert property (p_rx_invert) else $error("Receive inversion wrong");

endmodule

/* ssdr_peer.sv */
/*
 Far-side peer model: samples the DDR data and forwarded clock pins
 mid-phase, frames received words, and sends a repeating serial pattern.
 Assumes transmitted words have their top bit set so framing can start.
*/
`timescale 1ns/100ps
module ssdr_peer (
    input  wire logic link_clk,
    input  wire logic tx_data_pin,
    input  wire logic tx_clk_pin,
    output logic      rx_data_pin
);
    logic [7:0]  rx_pat;
    logic [7:0]  sh;
    int          cnt;
    int          pos;
    logic [15:0] ck_hist;
    logic [7:0]  got[$];

    // ==========================================================
    // Pin sampling and word framing
    task automatic take(input logic b);
        if (cnt != 0 || b === 1'b1) begin
            sh = {sh[6:0], b};
            cnt++;
        end
        if (cnt == 8) begin
            got.push_back(sh);
            cnt = 0;
        end
        ck_hist = {ck_hist[14:0], tx_clk_pin};
    endtask

    initial begin
        rx_pat = 8'hB4;
        sh = 8'h00;
        cnt = 0;
        pos = 0;
        ck_hist = 16'h0000;
        rx_data_pin = 1'b0;
    end

    always @(posedge link_clk) begin
        #8;
        take(tx_data_pin);
    end

    always @(negedge link_clk) begin
        #8;
        take(tx_data_pin);
    end

    // ==========================================================
    // Serial source, MSB first, one bit per link cycle
    always @(posedge link_clk) begin
        #2;
        rx_data_pin = rx_pat[7-pos];
        pos = (pos + 1) % 8;
    end
endmodule

/* tb.sv */
/*
 Self-checking testbench for ssdr_top with the peer model on the pins.
 Assumes the design's hand-over timing; no software-visible registers.
*/
`timescale 1ns/100ps
module tb;
    logic       core_clk;
    logic       sys_rst;
    logic       link_clk;
    logic [7:0] tx_word;
    logic       tx_valid;
    logic       tx_ready;
    logic [3:0] fwd_div;
    logic [2:0] inv_sel;
    logic       rx_slip;
    logic [7:0] rx_word;
    logic       rx_valid;
    logic       rx_ready;
    logic       rx_overflow;
    logic       tx_data_pin;
    logic       tx_clk_pin;
    logic       rx_data_pin;
    int         n_fail;
    int         cmp_count;

    ssdr_top u_ssdr_top (.core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .fwd_div(fwd_div),
        .inv_sel(inv_sel), .rx_slip(rx_slip), .rx_word(rx_word), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_overflow(rx_overflow), .tx_data_pin(tx_data_pin),
        .tx_clk_pin(tx_clk_pin), .rx_data_pin(rx_data_pin));
    ssdr_peer u_ssdr_peer (.link_clk(link_clk), .tx_data_pin(tx_data_pin),
        .tx_clk_pin(tx_clk_pin), .rx_data_pin(rx_data_pin));

    // ==========================================================
    // Clocks and shared tasks
    always #50 core_clk = ~core_clk;
    always #16 link_clk = ~link_clk;

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic pop(output logic [7:0] w);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        while (rx_valid !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (rx_valid !== 1'b1) n_fail++;
        rx_ready = 1'b1;
        w = rx_word;
        @(posedge core_clk);
        #1;
        rx_ready = 1'b0;
    endtask

    task automatic send(input logic [7:0] w);
        logic ok;
        tx_word = w;
        tx_valid = 1'b1;
        ok = 1'b0;
        while (ok !== 1'b1) begin
            ok = tx_ready;
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic wait_got(input int n);
        for (int i = 0; i < 400 && u_ssdr_peer.got.size() < n; i++) @(posedge link_clk);
        if (u_ssdr_peer.got.size() < n) n_fail++;
    endtask

    // Skip words framed before a slip or config change
    task automatic fresh(output logic [7:0] v);
        int n;
        n = 0;
        repeat (10) @(posedge core_clk);
        #1;
        while (rx_valid === 1'b1 && n < 100) begin
            pop(v);
            n++;
        end
        if (n >= 100) n_fail++;
        pop(v);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_align();
        logic [7:0] w;
        logic [7:0] v;
        chk("overflow_idle", rx_overflow, 1'b0);
        fresh(w);
        for (int i = 0; i < 12 && w !== 8'hB4; i++) begin
            @(posedge core_clk);
            #1;
            rx_slip = 1'b1;
            @(posedge core_clk);
            #1;
            rx_slip = 1'b0;
            fresh(v);
            chk("slip_word", v, {w[6:0], w[7]});
            w = v;
        end
        chk("aligned_word", w, 8'hB4);
        fresh(v);
        chk("aligned_hold", v, 8'hB4);
        inv_sel = 3'b001;
        fresh(v);
        chk("rx_inverted", v, 8'h4B);
        inv_sel = 3'b000;
        $display("test align done");
    endtask

    task automatic t_tx();
        chk("tx_ready_idle", tx_ready, 1'b1);
        send(8'hA5);
        send(8'hC3);
        send(8'h96);
        tx_valid = 1'b0;
        wait_got(3);
        chk("tx_w0", u_ssdr_peer.got.pop_front(), 8'hA5);
        chk("tx_w1", u_ssdr_peer.got.pop_front(), 8'hC3);
        chk("tx_w2", u_ssdr_peer.got.pop_front(), 8'h96);
        inv_sel = 3'b110;
        repeat (10) @(posedge core_clk);
        #1;
        send(8'h5A);
        tx_valid = 1'b0;
        wait_got(1);
        chk("tx_inverted", u_ssdr_peer.got.pop_front(), 8'hA5);
        inv_sel = 3'b000;
        $display("test tx done");
    endtask

    task automatic t_fwd();
        logic [15:0] h;
        logic [3:0]  divs[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
        foreach (divs[i]) begin
            fwd_div = divs[i];
            repeat (20) @(posedge core_clk);
            @(negedge link_clk);
            #10;
            h = u_ssdr_peer.ck_hist;
            if (divs[i] < 4'h2) chk("fwd_bypass", h, 16'hAAAA);
            else if (divs[i] == 4'h2) chk("fwd_half", h, 16'hAAAA);
            else if (divs[i] == 4'h4) chk("fwd_div4", h inside {16'hCCCC, 16'h3333}, 1'b1);
            else chk("fwd_div8", h inside {16'hF0F0, 16'h3C3C, 16'h0F0F, 16'hC3C3}, 1'b1);
            @(posedge core_clk);
            #1;
        end
        fwd_div = 4'h0;
        $display("test fwd done");
    endtask

    task automatic t_buffer();
        logic [7:0] v;
        int         n;
        for (int i = 0; i < 200 && rx_overflow !== 1'b1; i++) @(posedge core_clk);
        #1;
        chk("overflow_set", rx_overflow, 1'b1);
        n = 0;
        while (rx_valid === 1'b1 && n < 150) begin
            pop(v);
            n++;
        end
        chk("drain_depth", n >= 16, 1'b1);
        chk("drain_empty", n < 150, 1'b1);
        chk("overflow_sticky", rx_overflow, 1'b1);
        $display("test buffer done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        core_clk = 1'b0;
        link_clk = 1'b0;
        sys_rst = 1'b1;
        tx_word = 8'h00;
        tx_valid = 1'b0;
        fwd_div = 4'h0;
        inv_sel = 3'b000;
        rx_slip = 1'b0;
        rx_ready = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        repeat (5) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        t_align();
        t_tx();
        t_fwd();
        t_buffer();
        close_out();
    end

    initial begin
        #3000000;
        n_fail++;
        $display("watchdog expired");
        close_out();
    end
endmodule
